/* logic/cache_reset_and_miss_monitor.sv */
// cache reset sequencing, miss refill timing and miss-rate monitor with apb registers
// How it works
// - a hardware reset restores all logic and registers to defaults and clears the tags over 450 cycles.
// - a fetch arriving while the tags are cleared is held with wait states and served afterwards.
// - a software reset restarts the state machine and the tag clear but keeps configuration registers.
// - the interrupt is raised when the miss count of the interval reaches the programmed threshold.
// - separate readable counts of misses and hits are kept per interval.
// - the interval is programmed in clock cycles and the counter reaches at least 10 ms.
// - the monitor counts only while in active mode and stays idle otherwise.
// - the refill request goes out 3 cycles after the miss.
// - the requested word is delivered 4 cycles after the last refill word arrives.
// - the line size is selectable at run time as 8, 16 or 32 bytes and sets the refill length.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "cache_params.svh"
module cache_reset_and_miss_monitor #(
  parameter int SETS = 64,
  parameter int MAX_INTERVAL_CYCLES = `MAX_INTERVAL_MS * `CLK_KHZ
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hard_cache_reset,
  input wire logic active_mode,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  output logic fetch_ready,
  output logic fetch_valid,
  output logic [31:0] fetch_rdata,
  output logic refill_req,
  output logic [31:0] refill_addr,
  output logic [5:0] refill_len,
  input wire logic refill_valid,
  input wire logic [31:0] refill_data,
  output logic irq
);
  localparam int IDXW = $clog2(SETS);
  localparam int TAGW = 32 - 5 - IDXW;
  localparam int ICW = $clog2(MAX_INTERVAL_CYCLES + 1);
  localparam logic [8:0] CLEAR_LAST = 9'(`TAG_CLEAR_CYCLES - 1);
  localparam logic [1:0] MISS_LOAD = 2'(`MISS_TO_REQ_CYC - 2);
  localparam logic [1:0] DLV_LOAD = 2'(`DELIVERY_CYC - 2);

  typedef struct packed {
    cache_types_pkg::cache_state_e state;
    logic [1:0] cnt;
    logic [3:0] wcnt;
    logic [3:0] words;
    logic [8:0] clear_cnt;
    logic clearing;
    logic [31:0] pend_addr;
    logic [3:0] pend_mask;
    logic refill_req;
    logic [31:0] refill_addr;
    logic [5:0] refill_len;
    logic fetch_valid;
    logic [31:0] fetch_rdata;
    logic [1:0] line_sel;
    logic mon_en;
    logic [ICW-1:0] interval;
    logic [31:0] threshold;
    logic [ICW-1:0] ivl_cnt;
    logic [31:0] run_hits;
    logic [31:0] run_misses;
    logic [31:0] hit_count;
    logic [31:0] miss_count;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] prdata;
  } state_s;

  state_s r;
  state_s next_r;

  function automatic state_s reset_state();
    state_s s;
    s = '0;
    s.state = cache_types_pkg::st_idle;
    s.clearing = 1'b1;
    s.line_sel = `LINE_SEL_RST;
    s.mon_en = `MON_EN_RST;
    s.threshold = `THRESHOLD_RST;
    s.irq_mask = `IRQ_MASK_RST;
    return s;
  endfunction

  function automatic logic [5:0] line_bytes(input logic [1:0] sel);
    if (sel == cache_types_pkg::line_8) begin
      return 6'h08;
    end else if (sel == cache_types_pkg::line_16) begin
      return 6'h10;
    end
    return 6'h20;
  endfunction

  function automatic logic [3:0] fill_mask(input logic [1:0] sel, input logic [1:0] chunk);
    if (sel == cache_types_pkg::line_8) begin
      return 4'h1 << chunk;
    end else if (sel == cache_types_pkg::line_16) begin
      return chunk[1] ? 4'hc : 4'h3;
    end
    return 4'hf;
  endfunction

  logic [TAGW-1:0] rd_tag;
  logic [3:0] rd_mask;
  logic [31:0] rd_data;
  logic tag_we;
  logic [IDXW-1:0] tag_widx;
  logic [TAGW-1:0] tag_wtag;
  logic [3:0] tag_wmask;
  logic data_we;
  logic [IDXW+2:0] data_widx;
  logic [2:0] fill_word;
  logic apb_wr;
  logic soft_pulse;
  logic abort;
  logic take;
  logic tag_hit;
  logic hit;
  logic hit_ev;
  logic miss_ev;
  logic last_word;
  logic counting;
  logic ivl_end;
  logic [31:0] hits_n;
  logic [31:0] misses_n;
  logic mapped;

  tag_store #(.SETS(SETS), .IDXW(IDXW), .TAGW(TAGW)) store (
    .clk(pclk),
    .lookup_idx(fetch_addr[5 +: IDXW]),
    .lookup_word(fetch_addr[4:2]),
    .rd_tag(rd_tag),
    .rd_mask(rd_mask),
    .rd_data(rd_data),
    .tag_we(tag_we),
    .tag_widx(tag_widx),
    .tag_wtag(tag_wtag),
    .tag_wmask(tag_wmask),
    .data_we(data_we),
    .data_widx(data_widx),
    .data_wdata(refill_data)
  );

  assign apb_wr = psel && penable && pwrite;
  assign soft_pulse = apb_wr && paddr == `OFS_COMMAND && pwdata[`CMD_SOFT_BIT];
  assign abort = soft_pulse || hard_cache_reset;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= `OFS_COMMAND;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = r.prdata;

  assign fetch_ready = r.state == cache_types_pkg::st_idle && !r.clearing;
  assign take = fetch_req && fetch_ready;
  assign tag_hit = rd_tag == fetch_addr[31 -: TAGW];
  assign hit = tag_hit && rd_mask[fetch_addr[4:3]];
  assign hit_ev = take && hit;
  assign miss_ev = take && !hit;
  assign fill_word = 3'(r.refill_addr[4:2] + r.wcnt[2:0]);
  assign last_word = r.state == cache_types_pkg::st_fill && refill_valid && r.wcnt == r.words - 4'h1;
  assign data_we = r.state == cache_types_pkg::st_fill && refill_valid;
  assign data_widx = {r.pend_addr[5 +: IDXW], fill_word};

  always_comb begin
    // the tag clear owns the write port, and blocks fetches while it runs
    tag_we = 1'b0;
    tag_widx = r.pend_addr[5 +: IDXW];
    tag_wtag = r.pend_addr[31 -: TAGW];
    tag_wmask = r.pend_mask;
    if (r.clearing) begin
      tag_we = r.clear_cnt < 9'(SETS);
      tag_widx = r.clear_cnt[IDXW-1:0];
      tag_wmask = 4'h0;
    end else if (last_word) begin
      tag_we = 1'b1;
    end
  end

  assign counting = r.mon_en && active_mode && r.interval != '0;
  assign ivl_end = counting && (r.ivl_cnt + ICW'(1)) == r.interval;
  assign hits_n = r.run_hits + 32'(hit_ev);
  assign misses_n = r.run_misses + 32'(miss_ev);

  always_comb begin
    next_r = r;
    next_r.refill_req = 1'b0;
    next_r.fetch_valid = 1'b0;
    if (r.clearing) begin
      next_r.clear_cnt = r.clear_cnt + 9'h1;
      if (r.clear_cnt == CLEAR_LAST) begin
        next_r.clearing = 1'b0;
      end
    end
    unique case (r.state)
      cache_types_pkg::st_idle: begin
        if (hit_ev) begin
          next_r.fetch_valid = 1'b1;
          next_r.fetch_rdata = rd_data;
        end else if (miss_ev) begin
          next_r.state = cache_types_pkg::st_miss_wait;
          next_r.cnt = MISS_LOAD;
          next_r.pend_addr = fetch_addr;
          next_r.refill_len = line_bytes(r.line_sel);
          next_r.pend_mask = fill_mask(r.line_sel, fetch_addr[4:3]) | (tag_hit ? rd_mask : 4'h0);
        end
      end
      cache_types_pkg::st_miss_wait: begin
        if (r.cnt == 2'h0) begin
          next_r.refill_req = 1'b1;
          next_r.refill_addr = r.pend_addr & ~(32'(r.refill_len) - 32'h1);
          next_r.words = 4'(r.refill_len >> 2);
          next_r.wcnt = 4'h0;
          next_r.state = cache_types_pkg::st_fill;
        end else begin
          next_r.cnt = r.cnt - 2'h1;
        end
      end
      cache_types_pkg::st_fill: begin
        if (refill_valid) begin
          next_r.wcnt = r.wcnt + 4'h1;
          if (fill_word == r.pend_addr[4:2]) begin
            next_r.fetch_rdata = refill_data;
          end
          if (last_word) begin
            next_r.state = cache_types_pkg::st_deliver;
            next_r.cnt = DLV_LOAD;
          end
        end
      end
      cache_types_pkg::st_deliver: begin
        if (r.cnt == 2'h0) begin
          next_r.fetch_valid = 1'b1;
          next_r.state = cache_types_pkg::st_idle;
        end else begin
          next_r.cnt = r.cnt - 2'h1;
        end
      end
      default: begin
        next_r.state = cache_types_pkg::st_idle;
      end
    endcase
    // register writes; irq status is cleared first so a same-cycle event wins
    if (apb_wr) begin
      unique case (paddr)
        `OFS_CTRL: begin
          next_r.line_sel = pwdata[`CTRL_SEL_LSB +: 2];
          next_r.mon_en = pwdata[`CTRL_MON_BIT];
        end
        `OFS_INTERVAL: next_r.interval = pwdata[ICW-1:0];
        `OFS_THRESHOLD: next_r.threshold = pwdata;
        `OFS_IRQ_STATUS: next_r.irq_status = r.irq_status & ~pwdata[1:0];
        `OFS_IRQ_MASK: next_r.irq_mask = pwdata[1:0];
        default: begin
        end
      endcase
    end
    if (counting) begin
      if (ivl_end) begin
        next_r.hit_count = hits_n;
        next_r.miss_count = misses_n;
        next_r.run_hits = 32'h0;
        next_r.run_misses = 32'h0;
        next_r.ivl_cnt = '0;
        next_r.irq_status[`IRQ_IVL_BIT] = 1'b1;
      end else begin
        next_r.run_hits = hits_n;
        next_r.run_misses = misses_n;
        next_r.ivl_cnt = r.ivl_cnt + ICW'(1);
      end
      if (miss_ev && misses_n == r.threshold) begin
        next_r.irq_status[`IRQ_THR_BIT] = 1'b1;
      end
    end
    if (psel && !penable) begin
      unique case (paddr)
        `OFS_CTRL: next_r.prdata = 32'({r.mon_en, r.line_sel});
        `OFS_STATUS: next_r.prdata = 32'({r.state, r.clearing});
        `OFS_INTERVAL: next_r.prdata = 32'(r.interval);
        `OFS_THRESHOLD: next_r.prdata = r.threshold;
        `OFS_HITS: next_r.prdata = r.hit_count;
        `OFS_MISSES: next_r.prdata = r.miss_count;
        `OFS_IRQ_STATUS: next_r.prdata = 32'(r.irq_status);
        `OFS_IRQ_MASK: next_r.prdata = 32'(r.irq_mask);
        default: next_r.prdata = 32'h0;
      endcase
    end
    if (soft_pulse) begin
      next_r.state = cache_types_pkg::st_idle;
      next_r.clearing = 1'b1;
      next_r.clear_cnt = 9'h0;
      next_r.refill_req = 1'b0;
      next_r.fetch_valid = 1'b0;
    end
    if (hard_cache_reset) begin
      next_r = reset_state();
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= reset_state();
    end else begin
      r <= next_r;
    end
  end

  assign fetch_valid = r.fetch_valid;
  assign fetch_rdata = r.fetch_rdata;
  assign refill_req = r.refill_req;
  assign refill_addr = r.refill_addr;
  assign refill_len = r.refill_len;
  assign irq = |(r.irq_status & r.irq_mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence miss_seen;
    miss_ev && !abort;
  endsequence
  sequence last_seen;
    last_word && !abort;
  endsequence

  clear_length_a: assert property ($fell(r.clearing) && !$past(hard_cache_reset) |->
    $past(r.clear_cnt) == CLEAR_LAST) else $error("tag clear did not last 450 cycles");
  hold_fetch_a: assert property (r.clearing |-> !fetch_ready && !fetch_valid)
    else $error("fetch served during tag clear");
  soft_keeps_a: assert property (soft_pulse && !hard_cache_reset |=> r.clearing &&
    r.line_sel == $past(r.line_sel) && r.threshold == $past(r.threshold))
    else $error("soft reset disturbed configuration");
  thr_irq_a: assert property (counting && miss_ev && misses_n == r.threshold && !abort
    |=> r.irq_status[`IRQ_THR_BIT]) else $error("threshold interrupt not raised");
  miss_count_a: assert property (counting && !ivl_end && !hard_cache_reset |=>
    r.run_misses == $past(r.run_misses) + 32'($past(miss_ev)))
    else $error("miss count wrong");
  ivl_latch_a: assert property (ivl_end && !hard_cache_reset |=> r.run_hits == 32'h0 &&
    r.hit_count == $past(hits_n) && r.miss_count == $past(misses_n))
    else $error("interval counts not latched");
  sleep_idle_a: assert property (!active_mode && !abort |=> $stable(r.run_hits) &&
    $stable(r.run_misses) && $stable(r.ivl_cnt)) else $error("monitor counted in sleep");
  req_delay_a: assert property (miss_seen ##1 (!abort)[*3] |-> refill_req)
    else $error("refill request not 3 cycles after miss");
  no_early_req_a: assert property (miss_seen |-> !refill_req ##1 !refill_req)
    else $error("refill request too early");
  deliver_a: assert property (last_seen ##1 (!abort)[*4] |-> fetch_valid)
    else $error("word not delivered 4 cycles after refill");
  line_len_a: assert property (refill_req |-> (refill_len == 6'h08 || refill_len == 6'h10 ||
    refill_len == 6'h20) && (refill_addr[4:0] & 5'(refill_len - 6'h1)) == 5'h0)
    else $error("refill length or alignment wrong");
endmodule

/* logic/cache_params.svh */
// offsets, field positions, reset values and timing counts of the cache monitor
`ifndef CACHE_PARAMS_SVH
`define CACHE_PARAMS_SVH

`define CLK_KHZ 25000
`define MAX_INTERVAL_MS 10
`define TAG_CLEAR_CYCLES 450
`define MISS_TO_REQ_CYC 3
`define DELIVERY_CYC 4

`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INTERVAL 8'h08
`define OFS_THRESHOLD 8'h0c
`define OFS_HITS 8'h10
`define OFS_MISSES 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1c
`define OFS_COMMAND 8'h20

`define CTRL_SEL_LSB 0
`define CTRL_MON_BIT 2
`define CMD_SOFT_BIT 0
`define IRQ_THR_BIT 0
`define IRQ_IVL_BIT 1

`define LINE_SEL_RST 2'h0
`define MON_EN_RST 1'h1
`define THRESHOLD_RST 32'h0000_0000
`define IRQ_MASK_RST 2'h0

`endif

/* logic/cache_types_pkg.sv */
// types shared by the cache controller files
package cache_types_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_miss_wait = 4'h2,
    st_fill = 4'h4,
    st_deliver = 4'h8
  } cache_state_e;

  typedef enum logic [1:0] {
    line_8 = 2'h0,
    line_16 = 2'h1,
    line_32 = 2'h2
  } line_sel_e;
endpackage

/* logic/tag_store.sv */
// tag, valid-chunk mask and data arrays of the cache
`timescale 1ns/1ns
module tag_store #(
  parameter int SETS = 64,
  parameter int IDXW = 6,
  parameter int TAGW = 21
)(
  input wire logic clk,
  input wire logic [IDXW-1:0] lookup_idx,
  input wire logic [2:0] lookup_word,
  output logic [TAGW-1:0] rd_tag,
  output logic [3:0] rd_mask,
  output logic [31:0] rd_data,
  input wire logic tag_we,
  input wire logic [IDXW-1:0] tag_widx,
  input wire logic [TAGW-1:0] tag_wtag,
  input wire logic [3:0] tag_wmask,
  input wire logic data_we,
  input wire logic [IDXW+2:0] data_widx,
  input wire logic [31:0] data_wdata
);
  logic [TAGW-1:0] tags [SETS];
  logic [3:0] masks [SETS];
  logic [31:0] words [SETS*8];

  // one 4-bit mask per set: one bit per physical 8-byte chunk
  assign rd_tag = tags[lookup_idx];
  assign rd_mask = masks[lookup_idx];
  assign rd_data = words[{lookup_idx, lookup_word}];

  always_ff @(posedge clk) begin
    if (tag_we) begin
      tags[tag_widx] <= tag_wtag;
      masks[tag_widx] <= tag_wmask;
    end
    if (data_we) begin
      words[data_widx] <= data_wdata;
    end
  end
endmodule

/* tb/refill_partner.sv */
// refill partner model: flash or otp controller answering line refills
`timescale 1ns/1ns
module refill_partner #(
  parameter int T_CMD = 2,
  parameter int T_ADDR = 8,
  parameter int T_DUM = 4,
  parameter int T_PIPE = 1
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic otp_mode,
  input wire logic refill_req,
  input wire logic [31:0] refill_addr,
  input wire logic [5:0] refill_len,
  output logic refill_valid,
  output logic [31:0] refill_data
);
  logic [31:0] cur;
  logic [3:0] left;
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refill_valid <= 1'b0;
      refill_data <= 32'h0000_0000;
      cur <= 32'h0000_0000;
      left <= 4'h0;
      cnt <= 0;
    end else begin
      refill_valid <= 1'b0;
      // released data lines keep moving
      refill_data <= ~refill_data;
      if (refill_req) begin
        cur <= refill_addr;
        left <= refill_len[5:2];
        cnt <= otp_mode ? 2 : 2 + T_CMD + T_ADDR + T_DUM + 8;
      end else if (left != 4'h0) begin
        if (cnt > 1) begin
          cnt <= cnt - 1;
        end else begin
          refill_valid <= 1'b1;
          refill_data <= {cur[15:0], cur[15:0] ^ 16'hc3a5};
          cur <= cur + 32'h0000_0004;
          left <= left - 4'h1;
          cnt <= otp_mode ? 1 : (left == 4'h2 ? 8 + T_PIPE : 8);
        end
      end
    end
  end
endmodule

/* tb/test_cache_reset_and_miss_monitor.sv */
// self-checking bench for cache resets, refill timing and the miss monitor
`timescale 1ns/1ns
`include "cache_params.svh"
module test_cache_reset_and_miss_monitor;
  localparam int IVL = 300;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic hard_cache_reset, active_mode, fetch_req, fetch_ready, fetch_valid;
  logic refill_req, refill_valid, irq, otp_mode;
  logic [7:0] paddr;
  logic [5:0] refill_len;
  logic [31:0] pwdata, prdata, fetch_addr, fetch_rdata, refill_addr, refill_data, rd;
  int num_errors = 0;
  int n_tests = 0;
  int waited;
  int cyc = 0;

  cache_reset_and_miss_monitor #(.SETS(16), .MAX_INTERVAL_CYCLES(1000)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hard_cache_reset(hard_cache_reset), .active_mode(active_mode), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_rdata(fetch_rdata), .refill_req(refill_req), .refill_addr(refill_addr),
    .refill_len(refill_len), .refill_valid(refill_valid), .refill_data(refill_data),
    .irq(irq));

  refill_partner partner (
    .pclk(pclk), .presetn(presetn), .otp_mode(otp_mode), .refill_req(refill_req),
    .refill_addr(refill_addr), .refill_len(refill_len), .refill_valid(refill_valid),
    .refill_data(refill_data));

  always @(posedge pclk) cyc <= cyc + 1;

  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    chk(32'h0, 32'h1);
    conclude();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // len 0 expects a hit
  task automatic fetch(input logic [31:0] a, input int len);
    int n, t, tq, tl, words;
    logic [31:0] w;
    w = a & 32'hffff_fffc;
    fetch_req <= 1'b1;
    fetch_addr <= a;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (fetch_ready !== 1'b1 && n < 1000);
    if (fetch_ready !== 1'b1) hang();
    waited = n;
    fetch_req <= 1'b0;
    t = 0;
    tq = 0;
    tl = 0;
    words = 0;
    do begin
      @(posedge pclk);
      t++;
      if (refill_req === 1'b1) begin
        tq = t;
        chk(refill_len, len);
        chk(refill_addr, a & ~(len - 1));
      end
      if (refill_valid === 1'b1) begin
        tl = t;
        words++;
      end
    end while (fetch_valid !== 1'b1 && t < 2000);
    if (fetch_valid !== 1'b1) hang();
    chk(fetch_rdata, {w[15:0], w[15:0] ^ 16'hc3a5});
    if (len == 0) begin
      chk(t, 1);
      chk(tq, 0);
    end else begin
      chk(tq, 3);
      chk(words, len / 4);
      chk(t, tl + 4);
    end
  endtask

  task automatic wait_interval();
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 400);
    if (rd[1] !== 1'b1) hang();
  endtask

  task automatic t_reset();
    int n;
    logic [7:0] ofs[5] = '{`OFS_CTRL, `OFS_STATUS, `OFS_INTERVAL, `OFS_THRESHOLD, `OFS_IRQ_MASK};
    logic [31:0] val[5] = '{32'h4, 32'h2, 32'h0, 32'h0, 32'h0};
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (fetch_ready !== 1'b1 && n < 1000);
    chk(n, `TAG_CLEAR_CYCLES);
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, val[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_miss_sizes();
    int lens[3] = '{8, 16, 32};
    logic [31:0] a;
    for (int i = 0; i < 3; i++) begin
      a = 32'h1000 + 32'h100 * i;
      otp_mode <= (i != 1);
      apb(1'b1, `OFS_CTRL, 32'h4 | i);
      fetch(a + 32'h4, lens[i]);
      fetch(a + lens[i] - 4, 0);
    end
    $display("test miss sizes done");
  endtask

  task automatic t_hard_reset();
    apb(1'b1, `OFS_CTRL, 32'h1);
    hard_cache_reset <= 1'b1;
    @(posedge pclk);
    hard_cache_reset <= 1'b0;
    fetch(32'h1004, 8);
    chk(waited > 400, 1'b1);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h4);
    $display("test hard reset done");
  endtask

  task automatic t_soft_reset();
    apb(1'b1, `OFS_CTRL, 32'h6);
    apb(1'b1, `OFS_THRESHOLD, 32'h5);
    apb(1'b1, `OFS_COMMAND, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    fetch(32'h1204, 32);
    chk(waited > 390, 1'b1);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h6);
    apb(1'b0, `OFS_THRESHOLD, 32'h0);
    chk(rd, 32'h5);
    $display("test soft reset done");
  endtask

  task automatic t_monitor();
    int c0;
    apb(1'b1, `OFS_CTRL, 32'h4);
    apb(1'b1, `OFS_THRESHOLD, 32'h2);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    apb(1'b1, `OFS_INTERVAL, IVL);
    c0 = cyc;
    fetch(32'h2000, 8);
    chk(irq, 1'b0);
    fetch(32'h2000, 0);
    fetch(32'h2100, 8);
    chk(irq, 1'b1);
    wait_interval();
    chk((cyc - c0 >= IVL - 4) && (cyc - c0 <= IVL + 8), 1'b1);
    apb(1'b0, `OFS_HITS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, `OFS_MISSES, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
    chk(irq, 1'b0);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h2);
    active_mode <= 1'b0;
    fetch(32'h2200, 8);
    repeat (2 * IVL) @(posedge pclk);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    active_mode <= 1'b1;
    wait_interval();
    apb(1'b0, `OFS_MISSES, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `OFS_HITS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h2);
    apb(1'b1, `OFS_CTRL, 32'h3);
    fetch(32'h2304, 32);
    repeat (2 * IVL) @(posedge pclk);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test monitor done");
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hard_cache_reset = 1'b0;
    active_mode = 1'b1;
    fetch_req = 1'b0;
    fetch_addr = 32'h0;
    otp_mode = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_miss_sizes();
    t_hard_reset();
    t_soft_reset();
    t_monitor();
    conclude();
  end
endmodule
